// *** core/format_seq_pkg.sv ***
/*
  constants for the soft-sector format sequencer: register offsets, field layout
  of a microinstruction word, control byte codes, branch codes and reset values.
  assumes a 32-bit classic wishbone register bus with byte addresses.
*/
package format_seq_pkg;
  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] CONFIG_OFS = 8'h04;
  localparam logic [7:0] BRANCH_OFS = 8'h08;
  localparam logic [7:0] FILL_OFS = 8'h0c;
  localparam logic [7:0] STATUS_OFS = 8'h10;
  localparam logic [7:0] IRQ_STAT_OFS = 8'h14;
  localparam logic [7:0] IRQ_MASK_OFS = 8'h18;
  localparam logic [7:0] UCODE_OFS = 8'h80;
  // ----------------------------------------------------------------
  // register fields
  // ----------------------------------------------------------------
  localparam int CTRL_START_BIT = 0;
  localparam int CTRL_ABORT_BIT = 1;
  localparam int CTRL_ADDR_LSB = 8;
  localparam int CFG_SUPPRESS_BIT = 5;
  localparam int CFG_NO_CARRY_BIT = 6;
  localparam int STAT_RUN_BIT = 0;
  localparam int STAT_BRANCH_BIT = 1;
  localparam int STAT_XFER_BIT = 6;
  localparam int IRQ_INDEX_BIT = 0;
  localparam int IRQ_XFER_BIT = 1;
  localparam int IRQ_ECC_BIT = 2;
  localparam int IRQ_DONE_BIT = 3;
  localparam int IRQ_W = 4;
  // ----------------------------------------------------------------
  // microinstruction word: next, branch, control, data, count
  // ----------------------------------------------------------------
  localparam int UC_NEXT_LSB = 27;
  localparam int UC_BR_LSB = 24;
  localparam int UC_CTL_LSB = 16;
  localparam int UC_DATA_LSB = 8;
  localparam int UC_CNT_LSB = 0;
  localparam int UC_DEPTH = 32;
  localparam logic [7:0] CTL_WG_OFF = 8'h20;
  localparam logic [7:0] CTL_WG_ON = 8'h80;
  localparam int CTL_XFER_BIT = 0;
  localparam int CNT_SPECIAL_BIT = 7;
  localparam int CNT_ECC_BIT = 6;
  localparam logic [7:0] CNT_SYNC_ALIGN = 8'ha0;
  localparam logic [8:0] BLOCK_BYTES = 9'h100;
  localparam logic [2:0] BR_NONE = 3'h0;
  localparam logic [2:0] BR_STOP_INDEX = 3'h2;
  localparam logic [2:0] BR_ON_ECC = 3'h4;
  localparam logic [2:0] BR_INDEX_A = 3'h5;
  localparam logic [2:0] BR_INDEX_B = 3'h6;
  // ----------------------------------------------------------------
  // timing and reset values
  // ----------------------------------------------------------------
  localparam logic [2:0] RING_LAST = 3'h7;
  localparam logic [4:0] BRANCH_RST = 5'h00;
  localparam logic [7:0] FILL_RST = 8'h00;
  typedef enum logic [0:0] {
    SEQ_IDLE = 1'b0,
    SEQ_RUN = 1'b1
  } seq_state_t;
endpackage

// *** core/format_seq.sv ***
/*
  soft-sector format sequencer: a microprogrammed byte engine that writes a
  track format toward the drive as nrz bytes with a write gate.
  assumes a classic wishbone master, a synchronous index input, a buffer byte
  and an ecc byte offered by neighbouring logic whenever this block asks.
*/
// Chosen here: the address map and the Wishbone interface to the registers.
`timescale 1ns/1ps
// Behaviour
// (R1) control 20H gate off, 80H gate on
// (R2) post-id gap emits programmed count of 00H
// (R3) data field: buffer data, or fill if suppressed
// (R4) data transfer start sets transfer status flag
// (R5) inhibit carry allows a second 256-byte block
// (R6) control 01H transfers; count FFh moves 256
// (R7) four ecc bytes; branch 100 after last
// (R8) count holds bytes minus one; pad three zeros
// (R9) sync byte; pattern A0 realigns byte ring
// (R10) gaps and sectors repeat from same microcode
// (R11) host loads 13H to end the track
// (R12) end routine loops zeros, stops at index
// (R13) wait index edge; it sets branch flag
// (R14) write splice: gate off one byte time
// (R15) word holds next, branch, control, data, count
module format_seq (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic index_i,
  input wire logic [7:0] buf_data_i,
  input wire logic [7:0] ecc_byte_i,
  output logic buf_req_o,
  output logic [7:0] nrz_data_o,
  output logic nrz_strobe_o,
  output logic write_gate_out_o,
  output logic byte_clock_phase_o,
  output logic irq_o
);
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [8:0] byte_len(input logic [7:0] ctl, input logic [7:0] cnt);
    if (ctl[format_seq_pkg::CTL_XFER_BIT]) begin
      return {1'b0, cnt} + 9'h001;
    end else if (cnt[format_seq_pkg::CNT_SPECIAL_BIT]) begin
      return 9'h001;
    end else if (cnt[format_seq_pkg::CNT_ECC_BIT]) begin
      return {3'h0, cnt[5:0]} + 9'h001;
    end else begin
      return {1'b0, cnt} + 9'h001;
    end
  endfunction
  logic [31:0] ucode_mem [format_seq_pkg::UC_DEPTH];
  format_seq_pkg::seq_state_t state_reg;
  logic [31:0] ir_reg;
  logic [4:0] pc_reg;
  logic [8:0] cnt_reg;
  logic [2:0] ring_reg;
  logic carry_used_reg;
  logic idx_flag_reg;
  logic idx_d_reg;
  logic xfer_flag_reg;
  logic [4:0] branch_reg;
  logic [7:0] fill_reg;
  logic [6:0] config_reg;
  logic [format_seq_pkg::IRQ_W-1:0] irq_stat_reg;
  logic [format_seq_pkg::IRQ_W-1:0] irq_mask_reg;
  wire [4:0] ir_next = ir_reg[format_seq_pkg::UC_NEXT_LSB +: 5];
  wire [2:0] ir_br = ir_reg[format_seq_pkg::UC_BR_LSB +: 3];
  wire [7:0] ir_ctl = ir_reg[format_seq_pkg::UC_CTL_LSB +: 8];
  wire [7:0] ir_data = ir_reg[format_seq_pkg::UC_DATA_LSB +: 8];
  wire [7:0] ir_cnt = ir_reg[format_seq_pkg::UC_CNT_LSB +: 8];
  wire ir_xfer = ir_ctl[format_seq_pkg::CTL_XFER_BIT];
  wire ir_ecc = !ir_xfer && !ir_cnt[format_seq_pkg::CNT_SPECIAL_BIT] &&
                ir_cnt[format_seq_pkg::CNT_ECC_BIT];
  wire suppress = config_reg[format_seq_pkg::CFG_SUPPRESS_BIT];
  wire no_carry = config_reg[format_seq_pkg::CFG_NO_CARRY_BIT];
  wire running = state_reg == format_seq_pkg::SEQ_RUN;
  wire byte_tick = running && ring_reg == format_seq_pkg::RING_LAST;
  wire last_byte = byte_tick && cnt_reg == 9'h001;
  wire idx_rise = index_i && !idx_d_reg;

  // ----------------------------------------------------------------
  // wishbone slave
  // ----------------------------------------------------------------
  wire bus_req = wb_cyc_i && wb_stb_i;
  wire bus_wr = bus_req && wb_we_i && wb_ack_o;
  wire ucode_sel = wb_adr_i >= format_seq_pkg::UCODE_OFS;
  wire [4:0] ucode_idx = wb_adr_i[6:2];
  wire wr_ctrl = bus_wr && wb_sel_i[0] && wb_adr_i == format_seq_pkg::CTRL_OFS;
  wire start_req = wr_ctrl && wb_dat_i[format_seq_pkg::CTRL_START_BIT] && !running;
  wire abort_req = wr_ctrl && wb_dat_i[format_seq_pkg::CTRL_ABORT_BIT];
  wire [4:0] start_addr = wb_dat_i[format_seq_pkg::CTRL_ADDR_LSB +: 5];
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= bus_req && !wb_ack_o;
    end
  end
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (bus_req && !wb_ack_o) begin
      wb_dat_o <= 32'h0000_0000;
      if (ucode_sel) begin
        wb_dat_o <= ucode_mem[ucode_idx];
      end else begin
        unique case (wb_adr_i)
          format_seq_pkg::CTRL_OFS: begin
            wb_dat_o[format_seq_pkg::CTRL_START_BIT] <= running;
            wb_dat_o[format_seq_pkg::CTRL_ADDR_LSB +: 5] <= pc_reg;
          end
          format_seq_pkg::CONFIG_OFS: wb_dat_o[6:0] <= config_reg;
          format_seq_pkg::BRANCH_OFS: wb_dat_o[4:0] <= branch_reg;
          format_seq_pkg::FILL_OFS: wb_dat_o[7:0] <= fill_reg;
          format_seq_pkg::STATUS_OFS: begin
            wb_dat_o[format_seq_pkg::STAT_RUN_BIT] <= running;
            wb_dat_o[format_seq_pkg::STAT_BRANCH_BIT] <= idx_flag_reg;
            wb_dat_o[format_seq_pkg::STAT_XFER_BIT] <= xfer_flag_reg;
          end
          format_seq_pkg::IRQ_STAT_OFS: wb_dat_o[format_seq_pkg::IRQ_W-1:0] <= irq_stat_reg;
          format_seq_pkg::IRQ_MASK_OFS: wb_dat_o[format_seq_pkg::IRQ_W-1:0] <= irq_mask_reg;
          default: wb_dat_o <= 32'h0000_0000;
        endcase
      end
    end
  end
  // microcode store, byte lanes honoured
  always_ff @(posedge sys_clk_i) begin
    if (bus_wr && ucode_sel) begin
      for (int b = 0; b < 4; b++) begin
        if (wb_sel_i[b]) begin
          ucode_mem[ucode_idx][8*b +: 8] <= wb_dat_i[8*b +: 8];
        end
      end
    end
  end
  // host-loaded branch target, fill byte and options
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      branch_reg <= format_seq_pkg::BRANCH_RST;
      fill_reg <= format_seq_pkg::FILL_RST;
      config_reg <= 7'h00;
      irq_mask_reg <= '0;
    end else if (bus_wr && wb_sel_i[0]) begin
      unique case (wb_adr_i)
        format_seq_pkg::BRANCH_OFS: branch_reg <= wb_dat_i[4:0]; // R11
        format_seq_pkg::FILL_OFS: fill_reg <= wb_dat_i[7:0];
        format_seq_pkg::CONFIG_OFS: config_reg <= wb_dat_i[6:0];
        format_seq_pkg::IRQ_MASK_OFS: irq_mask_reg <= wb_dat_i[format_seq_pkg::IRQ_W-1:0];
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // index edge and branch-active flag
  // ----------------------------------------------------------------
  wire idx_used = last_byte && (ir_br == format_seq_pkg::BR_STOP_INDEX ||
                  ir_br == format_seq_pkg::BR_INDEX_A || ir_br == format_seq_pkg::BR_INDEX_B);
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      idx_d_reg <= 1'b0;
      idx_flag_reg <= 1'b0;
    end else begin
      idx_d_reg <= index_i;
      if (idx_rise && running) begin
        idx_flag_reg <= 1'b1; // R13
      end else if (start_req || (idx_used && idx_flag_reg)) begin
        idx_flag_reg <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // sequencer core
  // ----------------------------------------------------------------
  logic take_branch;
  logic stop_now;
  logic [4:0] next_pc;
  always_comb begin
    take_branch = 1'b0;
    stop_now = 1'b0;
    unique case (ir_br)
      format_seq_pkg::BR_STOP_INDEX: stop_now = idx_flag_reg; // R12
      format_seq_pkg::BR_ON_ECC: take_branch = ir_ecc; // R7
      format_seq_pkg::BR_INDEX_A, format_seq_pkg::BR_INDEX_B: take_branch = idx_flag_reg;
      default: take_branch = 1'b0;
    endcase
    next_pc = take_branch ? branch_reg : ir_next; // R15 R10
  end
  wire carry_again = last_byte && ir_xfer && no_carry && !carry_used_reg; // R5
  wire [31:0] next_word = ucode_mem[next_pc];
  wire [31:0] start_word = ucode_mem[start_addr];
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_reg <= format_seq_pkg::SEQ_IDLE;
      ir_reg <= 32'h0000_0000;
      pc_reg <= 5'h00;
      cnt_reg <= 9'h000;
      carry_used_reg <= 1'b0;
    end else if (abort_req) begin
      state_reg <= format_seq_pkg::SEQ_IDLE;
    end else if (start_req) begin
      state_reg <= format_seq_pkg::SEQ_RUN;
      pc_reg <= start_addr;
      ir_reg <= start_word;
      cnt_reg <= byte_len(start_word[format_seq_pkg::UC_CTL_LSB +: 8],
                          start_word[format_seq_pkg::UC_CNT_LSB +: 8]);
      carry_used_reg <= 1'b0;
    end else if (carry_again) begin
      cnt_reg <= format_seq_pkg::BLOCK_BYTES; // R5
      carry_used_reg <= 1'b1;
    end else if (last_byte) begin
      if (stop_now) begin
        state_reg <= format_seq_pkg::SEQ_IDLE; // R12
      end else begin
        pc_reg <= next_pc;
        ir_reg <= next_word;
        cnt_reg <= byte_len(next_word[format_seq_pkg::UC_CTL_LSB +: 8],
                            next_word[format_seq_pkg::UC_CNT_LSB +: 8]); // R6 R8
        carry_used_reg <= 1'b0;
      end
    end else if (byte_tick) begin
      cnt_reg <= cnt_reg - 9'h001;
    end
  end
  // bit ring: eight clocks to a byte, realigned by the sync pattern
  wire realign = start_req || (last_byte && !stop_now &&
                 next_word[format_seq_pkg::UC_CNT_LSB +: 8] == format_seq_pkg::CNT_SYNC_ALIGN);
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ring_reg <= 3'h0;
      byte_clock_phase_o <= 1'b0;
    end else begin
      if (realign) begin
        ring_reg <= 3'h0; // R9
        byte_clock_phase_o <= 1'b1;
      end else begin
        ring_reg <= ring_reg + 3'h1;
        byte_clock_phase_o <= ring_reg[2];
      end
    end
  end

  // ----------------------------------------------------------------
  // nrz byte and write gate
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      nrz_data_o <= 8'h00;
      nrz_strobe_o <= 1'b0;
      buf_req_o <= 1'b0;
    end else begin
      nrz_strobe_o <= byte_tick;
      buf_req_o <= byte_tick && ir_xfer && !suppress;
      if (byte_tick) begin
        if (ir_xfer) begin
          nrz_data_o <= suppress ? fill_reg : buf_data_i; // R3
        end else if (ir_ecc) begin
          nrz_data_o <= ecc_byte_i; // R7
        end else begin
          nrz_data_o <= ir_data; // R2 R9
        end
      end
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      write_gate_out_o <= 1'b0;
    end else if (abort_req || !running) begin
      write_gate_out_o <= 1'b0;
    end else if (byte_tick && ir_ctl == format_seq_pkg::CTL_WG_OFF) begin
      write_gate_out_o <= 1'b0; // R1 R14
    end else if (byte_tick && ir_ctl == format_seq_pkg::CTL_WG_ON) begin
      write_gate_out_o <= 1'b1; // R1
    end
  end

  // ----------------------------------------------------------------
  // status flag and interrupts
  // ----------------------------------------------------------------
  wire xfer_begin = byte_tick && ir_xfer && cnt_reg == byte_len(ir_ctl, ir_cnt) &&
                    !carry_used_reg;
  wire clr_status = bus_wr && wb_sel_i[0] && wb_adr_i == format_seq_pkg::STATUS_OFS &&
                    wb_dat_i[format_seq_pkg::STAT_XFER_BIT];
  wire clr_irq = bus_wr && wb_sel_i[0] && wb_adr_i == format_seq_pkg::IRQ_STAT_OFS;
  wire [format_seq_pkg::IRQ_W-1:0] irq_events = {last_byte && stop_now,
                                                 last_byte && ir_ecc,
                                                 xfer_begin,
                                                 idx_rise && running};

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      xfer_flag_reg <= 1'b0;
    end else if (xfer_begin) begin
      xfer_flag_reg <= 1'b1; // R4
    end else if (clr_status) begin
      xfer_flag_reg <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      irq_stat_reg <= '0;
      irq_o <= 1'b0;
    end else begin
      irq_stat_reg <= irq_events |
                      (irq_stat_reg & ~(clr_irq ? wb_dat_i[format_seq_pkg::IRQ_W-1:0] : '0));
      irq_o <= |(irq_stat_reg & irq_mask_reg);
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  sequence s_ecc_last;
    last_byte && ir_ecc && ir_br == format_seq_pkg::BR_ON_ECC;
  endsequence
  sequence s_splice_start;
    byte_tick && ir_ctl == format_seq_pkg::CTL_WG_OFF && cnt_reg == 9'h001;
  endsequence

  AST_WG_OFF: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // R1
    byte_tick && ir_ctl == format_seq_pkg::CTL_WG_OFF |=> !write_gate_out_o)
    else $error("write gate not dropped by control 20H");
  AST_WG_ON: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // R1
    byte_tick && ir_ctl == format_seq_pkg::CTL_WG_ON && !abort_req |=> write_gate_out_o)
    else $error("write gate not raised by control 80H");
  AST_GAP_BYTE: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // R2
    byte_tick && !ir_xfer && !ir_ecc |=> nrz_strobe_o && nrz_data_o == $past(ir_data))
    else $error("gap byte differs from data field");
  AST_FILL: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // R3
    byte_tick && ir_xfer |=> nrz_data_o == ($past(suppress) ? $past(fill_reg) : $past(buf_data_i)))
    else $error("data field byte source wrong");
  AST_XFER_FLAG: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // R4
    xfer_begin |=> xfer_flag_reg ##1 (xfer_flag_reg || $past(clr_status)))
    else $error("transfer flag not set at data start");
  AST_CARRY: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // R5
    carry_again && !abort_req |=> cnt_reg == format_seq_pkg::BLOCK_BYTES && running)
    else $error("second block not started");
  AST_LEN: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // R6
    last_byte && !stop_now && !carry_again && !abort_req |=>
    cnt_reg == byte_len(ir_ctl, ir_cnt))
    else $error("byte count not loaded from count field");
  AST_ECC_BRANCH: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // R7
    s_ecc_last ##0 !abort_req |=> pc_reg == $past(branch_reg))
    else $error("ecc branch not taken after last byte");
  AST_RING: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // R9
    realign |=> ring_reg == 3'h0 ##7 ring_reg == format_seq_pkg::RING_LAST)
    else $error("byte ring not realigned");
  AST_STOP: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // R12
    last_byte && stop_now && !abort_req && !start_req |=> !running && !write_gate_out_o)
    else $error("no stop at index");
  AST_IDX: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // R13
    idx_rise && running |=> idx_flag_reg)
    else $error("index did not set branch flag");
  AST_SPLICE: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // R14
    s_splice_start ##1 running [*7] |-> !write_gate_out_o)
    else $error("splice shorter than one byte");
endmodule

// *** tb/drive_model.sv ***
/*
  behavioural disk drive: records each nrz byte with the write gate level seen
  at its strobe, and makes one-clock index pulses on request.
  assumes the sequencer clock and a strobe that stands one cycle.
*/
`timescale 1ns/1ps
module drive_model (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic [7:0] nrz_data_i,
  input wire logic nrz_strobe_i,
  input wire logic write_gate_i,
  output logic index_o
);
  logic [7:0] got_d[$];
  logic got_g[$];
  initial index_o = 1'b0;
  // ----------------------------------------------------------------
  // byte capture
  // ----------------------------------------------------------------
  always @(posedge sys_clk_i) begin
    if (rst_n_i === 1'b1 && nrz_strobe_i === 1'b1) begin
      got_d.push_back(nrz_data_i);
      got_g.push_back(write_gate_i);
    end
  end
  // index pulse, leading edge counts
  task automatic pulse_index();
    @(posedge sys_clk_i);
    index_o <= 1'b1;
    @(posedge sys_clk_i);
    index_o <= 1'b0;
  endtask
endmodule

// *** tb/tb_top.sv ***
/*
  bench for the format sequencer: loads a short track program over wishbone,
  runs it against the drive model and compares the byte stream and registers.
  assumes the package constants and the drive model beside this file.
*/
`timescale 1ns/1ps
module tb_top;
  logic sys_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic ack;
  logic index;
  logic [7:0] buf_data = 8'h00;
  logic [7:0] ecc_byte = 8'h5a;
  logic buf_req;
  logic [7:0] nrz;
  logic strobe;
  logic gate;
  logic irq;
  logic phase;
  logic [3:0] s_hist = 4'h0;
  int failures = 0;
  int num_checks = 0;
  int buf_reqs = 0;
  logic [31:0] q;
  logic [7:0] exp_d[$];
  logic exp_g[$];
  always #10 sys_clk_i = ~sys_clk_i;
  format_seq i_format_seq (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .index_i(index), .buf_data_i(buf_data),
    .ecc_byte_i(ecc_byte), .buf_req_o(buf_req), .nrz_data_o(nrz), .nrz_strobe_o(strobe),
    .write_gate_out_o(gate), .byte_clock_phase_o(phase), .irq_o(irq));
  drive_model i_drive_model (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .nrz_data_i(nrz),
    .nrz_strobe_i(strobe), .write_gate_i(gate), .index_o(index));
  // ----------------------------------------------------------------
  // buffer source and helpers
  // ----------------------------------------------------------------
  always @(posedge sys_clk_i) begin
    if (buf_req === 1'b1) begin
      buf_data <= buf_data + 8'h01;
      buf_reqs <= buf_reqs + 1;
    end
  end
  // byte clock phase: high at each strobe, low four clocks after it
  always @(posedge sys_clk_i) begin
    s_hist <= {s_hist[2:0], strobe};
    if (strobe === 1'b1) check(phase, 32'h1);
    if (s_hist[3] === 1'b1) check(phase, 32'h0);
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] expd);
    num_checks++;
    if (seen !== expd) begin
      failures++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, expd);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge sys_clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= 4'hf;
    do begin
      @(posedge sys_clk_i);
      n++;
    end while (ack !== 1'b1 && n < 50);
    if (ack !== 1'b1) check(32'h0, 32'h1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask
  task automatic wait_bytes(input int n);
    for (int c = 0; c < 8 * n + 400 && i_drive_model.got_d.size() < n; c++) begin
      @(posedge sys_clk_i);
    end
  endtask
  task automatic poll_idle();
    q = 32'h1;
    for (int c = 0; c < 40 && q[format_seq_pkg::STAT_RUN_BIT] !== 1'b0; c++) begin
      wb(1'b0, format_seq_pkg::STATUS_OFS, 32'h0);
    end
  endtask
  task automatic push(input int n, input logic [7:0] d, input logic g);
    for (int k = 0; k < n; k++) begin
      exp_d.push_back(d);
      exp_g.push_back(g);
    end
  endtask
  // compares the expected bytes, then requires at least one idle loop byte
  task automatic check_stream(input int first);
    int k;
    for (k = 0; k < exp_d.size(); k++) begin
      check(i_drive_model.got_d[first + k], exp_d[k]);
      check(i_drive_model.got_g[first + k], exp_g[k]);
    end
    check(32'(i_drive_model.got_d.size() > first + k), 32'h1);
    for (k = first + k; k < i_drive_model.got_d.size(); k++) begin
      check({i_drive_model.got_g[k], i_drive_model.got_d[k]}, 32'h0);
    end
    exp_d.delete();
    exp_g.delete();
    i_drive_model.got_d.delete();
    i_drive_model.got_g.delete();
  endtask
  task automatic end_sim();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (30000) @(posedge sys_clk_i);
    failures++;
    end_sim();
  end
  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    logic [31:0] prog [10];
    int first;
    int base;
    prog[0] = {5'h00, 3'h6, 8'h20, 8'h00, 8'h00};
    prog[1] = {5'h02, 3'h0, 8'h20, 8'h00, 8'h00};
    prog[2] = {5'h03, 3'h0, 8'h80, 8'h00, 8'h04};
    prog[3] = {5'h04, 3'h0, 8'h02, 8'ha1, 8'ha0};
    prog[4] = {5'h05, 3'h0, 8'h01, 8'h00, 8'hff};
    prog[5] = {5'h07, 3'h4, 8'h00, 8'h00, 8'h43};
    prog[6] = {5'h08, 3'h0, 8'h00, 8'h00, 8'h02};
    prog[7] = {5'h08, 3'h0, 8'h00, 8'hee, 8'h00};
    prog[8] = {5'h09, 3'h0, 8'h20, 8'h00, 8'h00};
    prog[9] = {5'h09, 3'h2, 8'h00, 8'h00, 8'h00};
    repeat (2) @(posedge sys_clk_i);
    rst_n_i <= 1'b1;
    @(posedge sys_clk_i);
    check({ack, strobe, gate, irq, buf_req}, 32'h0);
    for (int n = 0; n < 10; n++) wb(1'b1, format_seq_pkg::UCODE_OFS + 8'(4 * n), prog[n]);
    wb(1'b1, format_seq_pkg::BRANCH_OFS, 32'h1);
    wb(1'b0, 8'h7c, 32'h0);
    check(q, 32'h0);
    $display("test setup done");
    // full sector: index wait, gap, sync, data, ecc branch, pad, splice, end loop
    wb(1'b1, format_seq_pkg::CTRL_OFS, 32'h1);
    wait_bytes(3);
    i_drive_model.pulse_index();
    for (int c = 0; c < 400 && gate !== 1'b1; c++) @(posedge sys_clk_i);
    wb(1'b1, format_seq_pkg::BRANCH_OFS, 32'h6);
    wait_bytes(i_drive_model.got_d.size() + 275);
    i_drive_model.pulse_index();
    poll_idle();
    first = 0;
    while (first < 40 && i_drive_model.got_g[first] !== 1'b1) first++;
    push(5, 8'h00, 1'b1);
    push(1, 8'ha1, 1'b1);
    for (int k = 0; k < 256; k++) push(1, 8'(k), 1'b1);
    push(4, 8'h5a, 1'b1);
    push(3, 8'h00, 1'b1);
    push(1, 8'h00, 1'b0);
    check_stream(first);
    check(gate, 32'h0);
    check(32'(buf_reqs), 32'd256);
    check(q & 32'h41, 32'h40);
    $display("test sector done");
    // interrupt status, mask and clear
    wb(1'b0, format_seq_pkg::IRQ_STAT_OFS, 32'h0);
    check(q, 32'hf);
    check(irq, 32'h0);
    wb(1'b1, format_seq_pkg::IRQ_MASK_OFS, 32'h8);
    repeat (2) @(posedge sys_clk_i);
    check(irq, 32'h1);
    wb(1'b1, format_seq_pkg::IRQ_STAT_OFS, 32'hf);
    repeat (2) @(posedge sys_clk_i);
    check(irq, 32'h0);
    wb(1'b0, format_seq_pkg::IRQ_STAT_OFS, 32'h0);
    check(q, 32'h0);
    wb(1'b1, format_seq_pkg::STATUS_OFS, 32'h40);
    wb(1'b0, format_seq_pkg::STATUS_OFS, 32'h0);
    check(q & 32'h40, 32'h0);
    $display("test interrupt done");
    // suppressed transfer with carry inhibit: two blocks of fill
    wb(1'b1, format_seq_pkg::CONFIG_OFS, 32'h60);
    wb(1'b1, format_seq_pkg::FILL_OFS, 32'h6d);
    base = buf_reqs;
    wb(1'b1, format_seq_pkg::CTRL_OFS, 32'h401);
    wait_bytes(524);
    i_drive_model.pulse_index();
    poll_idle();
    check(q & 32'h41, 32'h40);
    push(512, 8'h6d, 1'b0);
    push(4, 8'h5a, 1'b0);
    push(4, 8'h00, 1'b0);
    check_stream(0);
    check(32'(buf_reqs - base), 32'h0);
    $display("test fill done");
    // abort while writing: gate drops at once, pc stays put
    wb(1'b1, format_seq_pkg::CTRL_OFS, 32'h201);
    wait_bytes(2);
    wb(1'b1, format_seq_pkg::CTRL_OFS, 32'h2);
    wb(1'b0, format_seq_pkg::CTRL_OFS, 32'h0);
    check(q, 32'h200);
    check(gate, 32'h0);
    check(i_drive_model.got_g[0], 32'h1);
    i_drive_model.got_d.delete();
    i_drive_model.got_g.delete();
    $display("test abort done");
    end_sim();
  end
endmodule
